// >>> design/scwp_pkg.sv
// Constants, field layout and state types of the strap and serial port
package scwp_pkg;
    // Clock and strap window timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int STRAP_MIN_NS  = 9400;
    localparam int STRAP_MAX_NS  = 25600;
    localparam int STRAP_CYC_I   =
        (STRAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRAP_MAX_CYC = STRAP_MAX_NS / CLK_PERIOD_NS;
    localparam int HOLD_W        = 11;
    localparam logic [HOLD_W-1:0] STRAP_LAST =
        HOLD_W'(STRAP_CYC_I - 1);

    // Serial word layout
    localparam int ADDR_W    = 7;
    localparam int DATA_W    = 8;
    localparam int WORD_W    = 16;
    localparam int DEPTH     = 128;
    localparam int DIR_BIT   = 15;
    localparam int IDX_LSB   = 8;
    localparam int CMD_DIR   = 7;
    localparam logic [4:0] CNT_CMD  = 5'h08;
    localparam logic [4:0] CNT_FULL = 5'h10;

    // Register indices
    localparam logic [ADDR_W-1:0] IDX_RESET = 7'h00;
    localparam logic [ADDR_W-1:0] IDX_POWER = 7'h1E;

    // Power control fields and defaults
    localparam int SYNTH_BIT = 0;
    localparam int RX_BIT    = 1;
    localparam int TX_BIT    = 2;
    localparam int OSC_BIT   = 3;
    localparam int AIF_BIT   = 4;
    localparam int HIGHZ_BIT = 5;
    localparam logic [DATA_W-1:0] PWR_SW_RST = 8'h07;
    localparam logic [DATA_W-1:0] PWR_HW_RST = 8'h00;
    localparam logic [DATA_W-1:0] PWR_MASK   = 8'h3F;
    localparam logic [DATA_W-1:0] MEM_RST    = 8'h00;

    // Synchroniser vector lanes
    localparam int PIN_N    = 5;
    localparam int PIN_SCLK = 0;
    localparam int PIN_SDI  = 1;
    localparam int PIN_SDO  = 2;
    localparam int PIN_CSN  = 3;
    localparam int PIN_GPO  = 4;

    typedef enum logic {CFG_HOLD, CFG_RUN} scwp_cfg_t;
    typedef enum logic [1:0] {SER_SHIFT, SER_FETCH, SER_SEND} scwp_ser_t;
endpackage

// >>> design/scwp_regmem.sv
// Register storage: 128 bytes with per-word default tracking
module scwp_regmem
    import scwp_pkg::*;
(
    input  wire logic                      ref_clk,
    input  wire logic                      sys_rst,
    input  wire logic                      wr_en,
    input  wire logic [scwp_pkg::ADDR_W-1:0] wr_addr,
    input  wire logic [scwp_pkg::DATA_W-1:0] wr_data,
    input  wire logic                      clear_all,
    input  wire logic [scwp_pkg::ADDR_W-1:0] rd_addr,
    output logic      [scwp_pkg::DATA_W-1:0] rd_data_r
);
    logic [DATA_W-1:0] mem [DEPTH];
    logic [DEPTH-1:0]  valid_r;
    logic [DEPTH-1:0]  valid_nxt;
    logic [DATA_W-1:0] rd_data_nxt;

    // A valid bit per word lets a clear act in one cycle
    always_comb begin
        valid_nxt = valid_r;
        if (clear_all) begin
            valid_nxt = '0;
        end else if (wr_en) begin
            valid_nxt[wr_addr] = 1'b1;
        end
        rd_data_nxt = valid_r[rd_addr] ? mem[rd_addr] : MEM_RST;
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            valid_r   <= '0;
            rd_data_r <= MEM_RST;
        end else begin
            valid_r   <= valid_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    // Array itself needs no reset, the valid bits mask it
    always_ff @(posedge ref_clk) begin
        if (wr_en && !clear_all) begin
            mem[wr_addr] <= wr_data;
        end
    end
endmodule

// >>> design/scwp_top.sv
// Strap sampling, power control and 3-wire serial register port
// Operation
// - Configuration chosen from five pins at reset
// - Pins stay inputs 9.4us, then sampled
// - Data strap low hardware, high software
// - Software mode: output zero low 2-wire, high 3-wire
// - Software start: synth, rx, tx powered down
// - Hardware start: all functions powered up
// - Power bits 0..2 disable synth, rx, tx
// - Bits 3,4 power down oscillator, audio port
// - Bit 5 puts all outputs high-Z
// - Data sampled on rising serial clock
// - Word committed on chip select rising edge
// - Direction flag: 0 write, 1 read
// - Write carries 7-bit index, 8-bit data
// - Reads add serial data out wire
// - Hardware mode audio format from straps
// - 3-wire software mode: data out high-Z unless select low
// - Write to index zero restores defaults
module scwp_top
    import scwp_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       serial_clock,
    input  wire logic       serial_data_in,
    input  wire logic       chip_select_n,
    input  wire logic       serial_data_out_in,
    output logic            serial_data_out_drv_r,
    output logic            serial_data_out_oe_n_r,
    input  wire logic       general_output_zero_in,
    output logic            general_output_zero_drv_r,
    output logic            general_output_zero_oe_n_r,
    input  wire logic [1:0] gpo_value,
    output logic            config_done_r,
    output logic            control_mode_hw_r,
    output logic            serial_if_3wire_r,
    output logic            device_addr_sel_r,
    output logic            audio_if_master_select_r,
    output logic [1:0]      audio_if_format_strap_r,
    output logic            transmit_source_select_r,
    output logic            synth_disable_r,
    output logic            receiver_disable_r,
    output logic            transmitter_disable_r,
    output logic            oscillator_disable_r,
    output logic            audio_port_disable_r,
    output logic            outputs_high_z_r
);
    // Defaults of the power register for the sampled mode
    // Software start keeps synth, receiver and transmitter off
    function automatic logic [DATA_W-1:0] pwr_default(input logic hw);
        pwr_default = hw ? PWR_HW_RST : PWR_SW_RST;
    endfunction

    // Data-out pin is a plain output outside 3-wire software use
    function automatic logic pin_is_gpo(input logic hw, input logic w3);
        pin_is_gpo = hw | ~w3;
    endfunction

    // Pin synchronisers; stage one feeds stage two only
    // Reset clears both stages; false rises after release land in the
    // strap window, while the port is still off
    logic [PIN_N-1:0] meta_r;
    logic [PIN_N-1:0] pin_r;
    logic [PIN_N-1:0] pin_d_r;
    logic [PIN_N-1:0] pin_raw;

    assign pin_raw = {general_output_zero_in, chip_select_n,
                      serial_data_out_in, serial_data_in, serial_clock};

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r  <= '0;
            pin_r   <= '0;
            pin_d_r <= '0;
        end else begin
            meta_r  <= pin_raw;
            pin_r   <= meta_r;
            pin_d_r <= pin_r;
        end
    end

    // Edges seen on the second stage and its delayed copy
    // A held-low select never rises, so a word waits for its release
    logic sclk_rise;
    logic cs_rise;
    assign sclk_rise = pin_r[PIN_SCLK] & ~pin_d_r[PIN_SCLK];
    assign cs_rise   = pin_r[PIN_CSN] & ~pin_d_r[PIN_CSN];

    // Configuration state
    scwp_cfg_t         cfg_r, cfg_nxt;
    logic [HOLD_W-1:0] hold_r, hold_nxt;
    logic              strap_take;
    logic              hw_nxt, w3_nxt, dsel_nxt, ms_nxt, tx_nxt;
    logic [1:0]        fmt_nxt;
    logic [DATA_W-1:0] pwr_r, pwr_nxt;

    // Serial engine state
    scwp_ser_t         ser_r, ser_nxt;
    logic [WORD_W-1:0] sh_r, sh_nxt;
    logic [4:0]        cnt_r, cnt_nxt;
    logic [DATA_W-1:0] out_r, out_nxt;
    logic              sdo_nxt, sdo_oe_nxt, gpo_nxt, gpo_oe_nxt;

    // Memory port
    logic              mem_we, mem_clr;
    logic [DATA_W-1:0] mem_rdata;
    logic              port_on;
    logic [ADDR_W-1:0] wr_idx;

    // Hardware and 2-wire modes leave this port idle
    assign port_on = (cfg_r == CFG_RUN) & ~control_mode_hw_r
                     & serial_if_3wire_r;
    assign wr_idx  = sh_r[WORD_W-1-1:IDX_LSB];

    // The one cycle in which every strap is captured
    assign strap_take = (cfg_r == CFG_HOLD) && (hold_r == STRAP_LAST);

    // Strap window: count, then capture all straps at once
    always_comb begin
        cfg_nxt  = cfg_r;
        hold_nxt = hold_r;
        hw_nxt   = control_mode_hw_r;
        w3_nxt   = serial_if_3wire_r;
        dsel_nxt = device_addr_sel_r;
        ms_nxt   = audio_if_master_select_r;
        fmt_nxt  = audio_if_format_strap_r;
        tx_nxt   = transmit_source_select_r;
        unique case (cfg_r)
            CFG_HOLD: begin
                hold_nxt = hold_r + HOLD_W'(1);
                if (strap_take) begin
                    cfg_nxt  = CFG_RUN;
                    hw_nxt   = ~pin_r[PIN_SDI];
                    w3_nxt   = pin_r[PIN_GPO];
                    dsel_nxt = pin_r[PIN_CSN];
                    ms_nxt   = pin_r[PIN_SCLK];
                    fmt_nxt  = {pin_r[PIN_GPO], pin_r[PIN_SDO]};
                    tx_nxt   = pin_r[PIN_CSN];
                end
            end
            CFG_RUN: begin
                hold_nxt = hold_r;
            end
        endcase
    end

    // Shift, read-back and commit of serial words
    // Reads start only if select is low when the index completes;
    // bits past the sixteenth keep shifting and the last sixteen count
    always_comb begin
        ser_nxt = ser_r;
        sh_nxt  = sh_r;
        cnt_nxt = cnt_r;
        out_nxt = out_r;
        sdo_nxt = serial_data_out_drv_r;
        mem_we  = 1'b0;
        mem_clr = 1'b0;
        pwr_nxt = pwr_r;
        if (strap_take) begin
            pwr_nxt = pwr_default(~pin_r[PIN_SDI]);
        end
        if (port_on) begin
            unique case (ser_r)
                SER_SHIFT: begin
                    if (sclk_rise) begin
                        // MSB first: flag, index, data
                        sh_nxt = {sh_r[WORD_W-2:0], pin_r[PIN_SDI]};
                        if (cnt_r != CNT_FULL) begin
                            cnt_nxt = cnt_r + 5'h01;
                        end
                        if (cnt_r + 5'h01 == CNT_CMD && sh_r[CMD_DIR-1]
                            && !pin_r[PIN_CSN]) begin
                            ser_nxt = SER_FETCH;
                        end
                    end
                end
                SER_FETCH: begin
                    // Memory answered the index captured last cycle
                    out_nxt = (sh_r[ADDR_W-1:0] == IDX_POWER)
                              ? (pwr_r & PWR_MASK) : mem_rdata;
                    sdo_nxt = out_nxt[DATA_W-1];
                    ser_nxt = SER_SEND;
                end
                SER_SEND: begin
                    if (sclk_rise) begin
                        out_nxt = {out_r[DATA_W-2:0], 1'b0};
                        sdo_nxt = out_r[DATA_W-2];
                    end
                end
                default: begin
                    ser_nxt = SER_SHIFT;
                end
            endcase
            if (cs_rise) begin
                // Latch is on the select edge, not the 16th clock
                if (ser_r == SER_SHIFT && cnt_r == CNT_FULL
                    && !sh_r[DIR_BIT]) begin
                    // Index zero clears storage and restores power defaults
                    if (wr_idx == IDX_RESET) begin
                        mem_clr = 1'b1;
                        pwr_nxt = pwr_default(1'b0);
                    end else if (wr_idx == IDX_POWER) begin
                        pwr_nxt = sh_r[DATA_W-1:0] & PWR_MASK;
                    end else begin
                        mem_we = 1'b1;
                    end
                end
                ser_nxt = SER_SHIFT;
                cnt_nxt = '0;
            end
        end
        // Outside the port the pin shows a status level
        if (pin_is_gpo(control_mode_hw_r, serial_if_3wire_r)) begin
            sdo_nxt = gpo_value[1];
        end
    end

    // Pin drivers; enables are low while driving
    // Both enables stay high until the straps are taken
    always_comb begin
        sdo_oe_nxt = 1'b1;
        gpo_oe_nxt = 1'b1;
        gpo_nxt    = gpo_value[0];
        if (cfg_r == CFG_RUN && !pwr_r[HIGHZ_BIT]) begin
            gpo_oe_nxt = 1'b0;
            if (pin_is_gpo(control_mode_hw_r, serial_if_3wire_r)) begin
                sdo_oe_nxt = 1'b0;
            end else begin
                sdo_oe_nxt = pin_r[PIN_CSN];
            end
        end
    end

    // Storage reads the index a cycle early, ahead of the fetch state
    scwp_regmem u_mem (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .wr_en     (mem_we),
        .wr_addr   (wr_idx),
        .wr_data   (sh_r[DATA_W-1:0]),
        .clear_all (mem_clr),
        .rd_addr   (sh_nxt[ADDR_W-1:0]),
        .rd_data_r (mem_rdata)
    );

    // Register all state and every top-level output
    // Power outputs use the next value so they match the register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_r                      <= CFG_HOLD;
            hold_r                     <= '0;
            control_mode_hw_r          <= 1'b0;
            serial_if_3wire_r          <= 1'b0;
            device_addr_sel_r          <= 1'b0;
            audio_if_master_select_r   <= 1'b0;
            audio_if_format_strap_r    <= 2'h0;
            transmit_source_select_r   <= 1'b0;
            config_done_r              <= 1'b0;
            pwr_r                      <= PWR_SW_RST;
            ser_r                      <= SER_SHIFT;
            sh_r                       <= '0;
            cnt_r                      <= '0;
            out_r                      <= '0;
            serial_data_out_drv_r      <= 1'b0;
            serial_data_out_oe_n_r     <= 1'b1;
            general_output_zero_drv_r  <= 1'b0;
            general_output_zero_oe_n_r <= 1'b1;
            synth_disable_r            <= 1'b1;
            receiver_disable_r         <= 1'b1;
            transmitter_disable_r      <= 1'b1;
            oscillator_disable_r       <= 1'b0;
            audio_port_disable_r       <= 1'b0;
            outputs_high_z_r           <= 1'b0;
        end else begin
            cfg_r                      <= cfg_nxt;
            hold_r                     <= hold_nxt;
            control_mode_hw_r          <= hw_nxt;
            serial_if_3wire_r          <= w3_nxt;
            device_addr_sel_r          <= dsel_nxt;
            audio_if_master_select_r   <= ms_nxt;
            audio_if_format_strap_r    <= fmt_nxt;
            transmit_source_select_r   <= tx_nxt;
            config_done_r              <= (cfg_nxt == CFG_RUN);
            pwr_r                      <= pwr_nxt;
            ser_r                      <= ser_nxt;
            sh_r                       <= sh_nxt;
            cnt_r                      <= cnt_nxt;
            out_r                      <= out_nxt;
            serial_data_out_drv_r      <= sdo_nxt;
            serial_data_out_oe_n_r     <= sdo_oe_nxt;
            general_output_zero_drv_r  <= gpo_nxt;
            general_output_zero_oe_n_r <= gpo_oe_nxt;
            synth_disable_r            <= pwr_nxt[SYNTH_BIT];
            receiver_disable_r         <= pwr_nxt[RX_BIT];
            transmitter_disable_r      <= pwr_nxt[TX_BIT];
            oscillator_disable_r       <= pwr_nxt[OSC_BIT];
            audio_port_disable_r       <= pwr_nxt[AIF_BIT];
            outputs_high_z_r           <= pwr_nxt[HIGHZ_BIT];
        end
    end
endmodule

// >>> test/scwp_assertions.sv
// Concurrent checks on the strap and serial port top level
module scwp_assertions (
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    input wire logic       serial_data_in,
    input wire logic       chip_select_n,
    input wire logic       general_output_zero_in,
    input wire logic       serial_data_out_oe_n_r,
    input wire logic       general_output_zero_oe_n_r,
    input wire logic       config_done_r,
    input wire logic       control_mode_hw_r,
    input wire logic       serial_if_3wire_r,
    input wire logic [1:0] audio_if_format_strap_r,
    input wire logic       synth_disable_r,
    input wire logic       receiver_disable_r,
    input wire logic       transmitter_disable_r,
    input wire logic       oscillator_disable_r,
    input wire logic       audio_port_disable_r,
    input wire logic       outputs_high_z_r
);
    logic [5:0]  pwr;
    logic [10:0] hold_r;
    logic [10:0] hold_nxt;

    // Power bits gathered so a write shows as one change
    assign pwr = {outputs_high_z_r, audio_port_disable_r,
                  oscillator_disable_r, transmitter_disable_r,
                  receiver_disable_r, synth_disable_r};

    // Cycles since reset release; saturates so it never wraps
    always_comb hold_nxt = (hold_r == 11'h7FF) ? hold_r : hold_r + 11'h001;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) hold_r <= 11'h000;
        else hold_r <= hold_nxt;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_hold_window;
        $rose(config_done_r) |-> hold_r >= 11'h178 && hold_r <= 11'h400;
    endproperty
    a_hold_window: assert property (p_hold_window)
        else $error("straps sampled outside the hold window");
    property p_inputs_first;
        !config_done_r |-> serial_data_out_oe_n_r && general_output_zero_oe_n_r;
    endproperty
    a_inputs_first: assert property (p_inputs_first)
        else $error("pin driven before straps were sampled");
    property p_mode_strap;
        $rose(config_done_r) |->
            control_mode_hw_r == !$past(serial_data_in, 3);
    endproperty
    a_mode_strap: assert property (p_mode_strap)
        else $error("control mode differs from data strap");
    property p_if_strap;
        $rose(config_done_r) |->
            serial_if_3wire_r == $past(general_output_zero_in, 3);
    endproperty
    a_if_strap: assert property (p_if_strap)
        else $error("interface choice differs from output zero strap");
    property p_sw_start;
        $rose(config_done_r) && !control_mode_hw_r |-> pwr == 6'h07;
    endproperty
    a_sw_start: assert property (p_sw_start)
        else $error("software start not powered down");
    property p_hw_power;
        config_done_r && control_mode_hw_r |-> pwr == 6'h00;
    endproperty
    a_hw_power: assert property (p_hw_power)
        else $error("hardware mode power not all up");
    property p_config_kept;
        config_done_r && $past(config_done_r) |-> $stable(control_mode_hw_r)
            && $stable(serial_if_3wire_r) && $stable(audio_if_format_strap_r);
    endproperty
    a_config_kept: assert property (p_config_kept)
        else $error("configuration changed after sampling");
    property p_high_z;
        outputs_high_z_r [*2] |->
            serial_data_out_oe_n_r && general_output_zero_oe_n_r;
    endproperty
    a_high_z: assert property (p_high_z)
        else $error("pin driven while outputs high-Z set");
    property p_commit_on_select;
        config_done_r && $past(config_done_r) && !$stable(pwr) |->
            chip_select_n && $past(chip_select_n, 2);
    endproperty
    a_commit_on_select: assert property (p_commit_on_select)
        else $error("power register changed without select rise");
    property p_sdo_idle;
        config_done_r && !control_mode_hw_r && serial_if_3wire_r
            && chip_select_n [*5] |-> serial_data_out_oe_n_r;
    endproperty
    a_sdo_idle: assert property (p_sdo_idle)
        else $error("data out driven with select high");
endmodule

bind scwp_top scwp_assertions u_chk (.ref_clk, .sys_rst, .serial_data_in,
    .chip_select_n, .general_output_zero_in, .serial_data_out_oe_n_r,
    .general_output_zero_oe_n_r, .config_done_r, .control_mode_hw_r,
    .serial_if_3wire_r, .audio_if_format_strap_r, .synth_disable_r,
    .receiver_disable_r, .transmitter_disable_r, .oscillator_disable_r,
    .audio_port_disable_r, .outputs_high_z_r);

// >>> test/scwp_host_model.sv
// Host controller model driving the 3-wire serial control lines
module scwp_host_model (
    input  wire logic ref_clk,
    input  wire logic serial_data_out,
    output logic      serial_clock,
    output logic      serial_data_in,
    output logic      chip_select_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // Half of the 200 ns serial period, in bench clock cycles
    task automatic half_period();
        repeat (4) @(negedge ref_clk);
    endtask

    // Strap levels, held through reset until sampled
    task automatic set_lines(input logic sdi, input logic sclk,
                             input logic csn);
        serial_data_in = sdi;
        serial_clock = sclk;
        chip_select_n = csn;
    endtask

    // One word MSB first; clock stands low outside the frame
    task automatic xfer(input logic [15:0] word, input int nbits,
                        input bit pulse, output logic [7:0] rd);
        rd = 8'h00;
        @(negedge ref_clk);
        serial_clock = 1'b0;
        if (!pulse) chip_select_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            serial_data_in = word[15 - i];
            half_period();
            if (i >= 8) rd = {rd[6:0], serial_data_out};
            serial_clock = 1'b1;
            half_period();
            serial_clock = 1'b0;
        end
        half_period();
        // Short low pulse latches the word when select idles high
        if (pulse) begin
            chip_select_n = 1'b0;
            half_period();
        end
        chip_select_n = 1'b1;
        serial_data_in = ~serial_data_in;
    endtask
endmodule

// >>> test/scwp_top_tb.sv
// Self-checking bench for the strap and serial register port
module scwp_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import scwp_pkg::*;

    logic       ref_clk, sys_rst, sclk, sdi, csn, st_sdo, st_gpo, done;
    logic       sdo_pin, gpo_pin, sdo_drv, sdo_oe_n, gpo_drv, gpo_oe_n;
    logic       hw, if3, ms, txs, dsel;
    logic [3:0] pins;
    logic [1:0] fmt, gpo_value;
    logic [5:0] pwr;
    logic [7:0] rd;
    int         miscompares, samples_checked, cycles;

    scwp_top u_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .serial_clock(sclk),
        .serial_data_in(sdi), .chip_select_n(csn),
        .serial_data_out_in(sdo_pin), .serial_data_out_drv_r(sdo_drv),
        .serial_data_out_oe_n_r(sdo_oe_n), .general_output_zero_in(gpo_pin),
        .general_output_zero_drv_r(gpo_drv),
        .general_output_zero_oe_n_r(gpo_oe_n), .gpo_value(gpo_value),
        .config_done_r(done), .control_mode_hw_r(hw),
        .serial_if_3wire_r(if3), .device_addr_sel_r(dsel),
        .audio_if_master_select_r(ms), .audio_if_format_strap_r(fmt),
        .transmit_source_select_r(txs), .synth_disable_r(pwr[0]),
        .receiver_disable_r(pwr[1]), .transmitter_disable_r(pwr[2]),
        .oscillator_disable_r(pwr[3]), .audio_port_disable_r(pwr[4]),
        .outputs_high_z_r(pwr[5]));
    scwp_host_model u_host (.ref_clk(ref_clk), .serial_data_out(sdo_pin),
        .serial_clock(sclk), .serial_data_in(sdi), .chip_select_n(csn));

    // Released pins settle at their strap resistor level
    assign sdo_pin = sdo_oe_n ? st_sdo : sdo_drv;
    assign gpo_pin = gpo_oe_n ? st_gpo : gpo_drv;
    assign pins    = {sdo_oe_n, gpo_oe_n, sdo_pin, gpo_pin};

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Hang guard; the whole run needs about 2850 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Straps as {data, clock, select, data out, output zero}
    task automatic boot(input logic [4:0] s);
        @(negedge ref_clk);
        u_host.set_lines(s[4], s[3], s[2]);
        st_sdo = s[1];
        st_gpo = s[0];
        sys_rst = 1'b1;
        repeat (10) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (300) @(negedge ref_clk);
        check("early pins", 8'h06, {5'h00, sdo_oe_n, gpo_oe_n, done});
        for (int i = 0; i < 800 && done !== 1'b1; i++) @(negedge ref_clk);
        repeat (4) @(negedge ref_clk);
    endtask

    // Effect shows about three cycles after select rises
    task automatic wr(input logic [15:0] w, input int n, input bit pulse);
        u_host.xfer(w, n, pulse, rd);
        repeat (8) @(negedge ref_clk);
    endtask

    initial begin
        sys_rst = 1'b1;
        gpo_value = 2'b10;
        st_sdo = 1'b0;
        st_gpo = 1'b1;
        u_host.set_lines(1'b1, 1'b0, 1'b1);
        boot(5'b10101);
        check("mode", 8'h05, {5'h00, dsel, hw, if3});
        check("power", 8'h07, {2'b00, pwr});
        $display("test software boot done");
        wr(16'h1E00, 16, 1'b0);
        check("power", 8'h00, {2'b00, pwr});
        wr(16'h1E3F, 16, 1'b1);
        check("power", 8'h3F, {2'b00, pwr});
        check("oe_n", 8'h03, {6'h00, sdo_oe_n, gpo_oe_n});
        wr(16'h9E00, 16, 1'b1);
        check("power", 8'h3F, {2'b00, pwr});
        $display("test write styles done");
        wr(16'h1E1A, 16, 1'b0);
        wr(16'h05A5, 16, 1'b0);
        wr(16'h1E00, 12, 1'b0);
        check("power", 8'h1A, {2'b00, pwr});
        wr(16'h9E00, 16, 1'b0);
        check("read", 8'h1A, rd);
        check("oe_n", 8'h01, {7'h00, sdo_oe_n});
        wr(16'h8500, 16, 1'b0);
        check("read", 8'hA5, rd);
        $display("test read back done");
        wr(16'h0000, 16, 1'b0);
        check("power", 8'h07, {2'b00, pwr});
        wr(16'h8500, 16, 1'b0);
        check("read", 8'h00, rd);
        $display("test register reset done");
        boot(5'b10100);
        check("mode", 8'h04, {5'h00, dsel, hw, if3});
        check("pins", 8'h02, {4'h0, pins});
        wr(16'h1E00, 16, 1'b0);
        check("power", 8'h07, {2'b00, pwr});
        $display("test 2-wire boot done");
        boot(5'b01010);
        check("config", 8'h2A, {1'b0, dsel, hw, if3, ms, fmt, txs});
        check("power", 8'h00, {2'b00, pwr});
        check("pins", 8'h02, {4'h0, pins});
        wr(16'h1E3F, 16, 1'b0);
        check("power", 8'h00, {2'b00, pwr});
        $display("test hardware boot done");
        give_verdict();
    end
endmodule
